/* design/mfr_top.sv */
// MAC address filter, pad strip decision and transmit retry/backoff control.
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module mfr_top (
    input wire logic ref_clk, // Clock.
    input wire logic rst_n, // Async reset.
    input wire logic [11:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [11:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read valid.
    input wire logic s_axi_rready, // Read ready.
    input wire logic rxHdrValid, // Received header valid pulse.
    input wire mfr_pkg::mfr_rxhdr_s rxHdr, // Received header.
    output logic rxAccept, // Frame accepted pulse.
    output logic rxStripPadFcs, // Strip pad and FCS, with rxAccept.
    output logic rxWake, // Wakeup pulse.
    input wire logic txStart, // Frame ready to send pulse.
    input wire logic txAttemptEnd, // Attempt finished pulse.
    input wire logic txCollision, // Collision seen, with txAttemptEnd.
    input wire logic txLateColl, // Collision was late, with txAttemptEnd.
    output logic txGo, // Start an attempt pulse.
    output logic txBusy, // Frame in progress.
    output logic txDone, // Frame finished pulse.
    output mfr_pkg::mfr_txstat_s txStatus, // Status of last frame.
    output logic irq // Interrupt level.
);
    import mfr_pkg::*;

    logic [31:0] ctrl_q, ctrl_d, stah_q, stah_d, stal_q, stal_d;
    logic [31:0] hashh_q, hashh_d, hashl_q, hashl_d, wake_q, wake_d;
    logic [4:0] ist_q, ist_d, imsk_q, imsk_d;
    logic awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
    logic [11:0] awa_q, awa_d;
    logic [31:0] wda_q, wda_d, rd_q, rd_d;
    logic [3:0] wst_q, wst_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic irq_q, irq_d;
    logic haveAw_q, haveAw_d, haveW_q, haveW_d;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    function automatic logic known(input logic [11:0] a);
        return a == ADDR_CTRL || a == ADDR_STAH || a == ADDR_STAL || a == ADDR_HASHH ||
               a == ADDR_HASHL || a == ADDR_WAKE || a == ADDR_IRQST || a == ADDR_IRQMSK ||
               a == ADDR_TXST;
    endfunction

    // Receive path.
    logic acc_q, acc_d, strip_q, strip_d, wk_q, wk_d;
    logic isBcast, isMcast, match, hashHit;
    logic [5:0] hidx;
    always_comb
    begin
        isBcast = rxHdr.dstAddr == 48'hFFFF_FFFF_FFFF;
        isMcast = rxHdr.dstAddr[40];
        hidx = rxHdr.dstAddr[5:0];
        hashHit = hidx[5] ? hashh_q[hidx[4:0]] : hashl_q[hidx[4:0]];
        if (isBcast)
            match = !ctrl_q[BROADCAST_REJECT_REJ_BIT];
        else if (ctrl_q[HASH_SEL_BIT] && (isMcast || ctrl_q[HASH_ONLY_BIT]))
            match = hashHit;
        else
            match = rxHdr.dstAddr == {stah_q[15:0], stal_q};
        acc_d = rxHdrValid && match;
        strip_d = rxHdrValid && match && ctrl_q[PAD_STRIP_BIT] &&
                  rxHdr.lenField < PAD_MIN_LEN;
        wk_d = rxHdrValid && rxHdr.isWakeup && wake_q[WAKE_EN_BIT];
    end

    // Transmit path.
    mfr_txst_e ts_q, ts_d;
    logic [4:0] att_q, att_d;
    logic [19:0] lfsr_q, lfsr_d;
    logic [9:0] bo_q, bo_d;
    logic [11:0] slot_q, slot_d;
    logic go_q, go_d, done_q, done_d, busy_q, busy_d;
    mfr_txstat_s tst_q, tst_d;
    logic [3:0] k, lim, nb;
    always_comb
    begin
        lfsr_d = {lfsr_q[18:0], lfsr_q[19] ^ lfsr_q[16]};
        ts_d = ts_q;
        {att_d, bo_d, slot_d, tst_d} = {att_q, bo_q, slot_q, tst_q};
        {go_d, done_d} = 2'b00;
        k = (att_q > 5'(K_MAX)) ? K_MAX : att_q[3:0];
        unique case (ctrl_q[BACKOFF_LIMIT_LSB +: 2])
            2'b00: lim = 4'hA;
            2'b01: lim = 4'h8;
            2'b10: lim = 4'h4;
            2'b11: lim = 4'h1;
        endcase
        nb = (k < lim) ? k : lim;
        unique case (ts_q)
            TX_IDLE:
                if (txStart)
                begin
                    att_d = 5'h01;
                    go_d = 1'b1;
                    tst_d = '0;
                    ts_d = TX_SEND;
                end
            TX_SEND:
                if (txAttemptEnd)
                begin
                    if (txLateColl)
                        tst_d.lateColl = 1'b1;
                    tst_d.attempts = att_q;
                    if (!txCollision)
                        ts_d = TX_DONE;
                    else if (ctrl_q[RETRY_DIS_BIT] || att_q == MAX_ATTEMPTS ||
                             (txLateColl && !ctrl_q[LATE_RETRY_BIT]))
                    begin
                        tst_d.retryErr = !txLateColl || ctrl_q[LATE_RETRY_BIT];
                        ts_d = TX_DONE;
                    end
                    else
                    begin
                        bo_d = lfsr_q[9:0] & 10'((11'h001 << nb) - 11'h001);
                        slot_d = SLOT_CYCLES;
                        ts_d = TX_BACKOFF;
                    end
                end
            TX_BACKOFF:
                if (bo_q == 10'h000)
                begin
                    att_d = att_q + 5'h01;
                    go_d = 1'b1;
                    ts_d = TX_SEND;
                end
                else if (slot_q == 12'h001)
                begin
                    slot_d = SLOT_CYCLES;
                    bo_d = bo_q - 10'h001;
                end
                else
                    slot_d = slot_q - 12'h001;
            TX_DONE:
            begin
                done_d = 1'b1;
                ts_d = TX_IDLE;
            end
            default:
                ts_d = TX_IDLE;
        endcase
        // Busy is registered from the next state so that it leaves the block from a flip-flop.
        busy_d = ts_d != TX_IDLE;
    end

    // Register bus.
    logic doWr, doRd;
    logic [4:0] ev;
    logic [31:0] rsel;
    always_comb
    begin
        {awr_d, wr_d, bv_d, arr_d, rv_d, awa_d, wda_d, wst_d, br_d, rr_d, rd_d} =
            {awr_q, wr_q, bv_q, arr_q, rv_q, awa_q, wda_q, wst_q, br_q, rr_q, rd_q};
        {haveAw_d, haveW_d, ctrl_d, stah_d, stal_d, hashh_d, hashl_d, wake_d, imsk_d} =
            {haveAw_q, haveW_q, ctrl_q, stah_q, stal_q, hashh_q, hashl_q, wake_q, imsk_q};
        rsel = 32'h0000_0000;
        if (s_axi_awvalid && awr_q)
        begin
            awa_d = s_axi_awaddr;
            haveAw_d = 1'b1;
            awr_d = 1'b0;
        end
        if (s_axi_wvalid && wr_q)
        begin
            wda_d = s_axi_wdata;
            wst_d = s_axi_wstrb;
            haveW_d = 1'b1;
            wr_d = 1'b0;
        end
        doWr = haveAw_q && haveW_q && !bv_q;
        if (doWr)
        begin
            unique case ({awa_q[11:2], 2'b00})
                ADDR_CTRL: ctrl_d = (ctrl_q & ~CTRL_WMASK) |
                                    (merge(ctrl_q, wda_q, wst_q) & CTRL_WMASK);
                ADDR_STAH: stah_d = merge(stah_q, wda_q, wst_q) & 32'h0000_FFFF;
                ADDR_STAL: stal_d = merge(stal_q, wda_q, wst_q);
                ADDR_HASHH: hashh_d = merge(hashh_q, wda_q, wst_q);
                ADDR_HASHL: hashl_d = merge(hashl_q, wda_q, wst_q);
                ADDR_WAKE: wake_d = merge(wake_q, wda_q, wst_q) & 32'h0000_0004;
                ADDR_IRQMSK: imsk_d = 5'(merge({27'h0, imsk_q}, wda_q, wst_q));
                default: ;
            endcase
            br_d = known({awa_q[11:2], 2'b00}) ? 2'b00 : 2'b10;
            bv_d = 1'b1;
            haveAw_d = 1'b0;
            haveW_d = 1'b0;
        end
        if (bv_q && s_axi_bready)
        begin
            bv_d = 1'b0;
            awr_d = 1'b1;
            wr_d = 1'b1;
        end
        doRd = s_axi_arvalid && arr_q;
        if (doRd)
        begin
            unique case ({s_axi_araddr[11:2], 2'b00})
                ADDR_CTRL: rsel = ctrl_q;
                ADDR_STAH: rsel = stah_q;
                ADDR_STAL: rsel = stal_q;
                ADDR_HASHH: rsel = hashh_q;
                ADDR_HASHL: rsel = hashl_q;
                ADDR_WAKE: rsel = wake_q;
                ADDR_IRQST: rsel = {27'h0, ist_q};
                ADDR_IRQMSK: rsel = {27'h0, imsk_q};
                ADDR_TXST: rsel = {25'h0, tst_q};
                default: rsel = 32'h0000_0000;
            endcase
            rd_d = rsel;
            rr_d = known({s_axi_araddr[11:2], 2'b00}) ? 2'b00 : 2'b10;
            rv_d = 1'b1;
            arr_d = 1'b0;
        end
        if (rv_q && s_axi_rready)
        begin
            rv_d = 1'b0;
            arr_d = 1'b1;
        end
        // Events win over the clear done by a status read in the same cycle.
        ev = 5'h00;
        ev[IRQ_RXOK] = acc_d;
        ev[IRQ_WAKE] = wk_d;
        ev[IRQ_TXDONE] = done_d;
        ev[IRQ_RTYERR] = done_d && tst_q.retryErr;
        ev[IRQ_LATE] = done_d && tst_q.lateColl;
        ist_d = ((doRd && {s_axi_araddr[11:2], 2'b00} == ADDR_IRQST) ? 5'h00 : ist_q) | ev;
        irq_d = |(ist_d & imsk_d);
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= CTRL_RESET;
            lfsr_q <= LFSR_SEED;
            ts_q <= TX_IDLE;
            {awr_q, wr_q, arr_q} <= 3'b111;
            {stah_q, stal_q, hashh_q, hashl_q, wake_q, ist_q, imsk_q, bv_q, rv_q, awa_q} <= '0;
            {wda_q, wst_q, br_q, rr_q, rd_q, haveAw_q, haveW_q, irq_q, acc_q, strip_q} <= '0;
            {wk_q, att_q, bo_q, slot_q, go_q, done_q, tst_q, busy_q} <= '0;
        end
        else
        begin
            {ctrl_q, stah_q, stal_q, hashh_q, hashl_q, wake_q} <=
                {ctrl_d, stah_d, stal_d, hashh_d, hashl_d, wake_d};
            {ist_q, imsk_q, awr_q, wr_q, arr_q, bv_q, rv_q, awa_q, wda_q, wst_q} <=
                {ist_d, imsk_d, awr_d, wr_d, arr_d, bv_d, rv_d, awa_d, wda_d, wst_d};
            {br_q, rr_q, rd_q, haveAw_q, haveW_q, irq_q, acc_q, strip_q, wk_q} <=
                {br_d, rr_d, rd_d, haveAw_d, haveW_d, irq_d, acc_d, strip_d, wk_d};
            {att_q, lfsr_q, bo_q, slot_q, go_q, done_q, tst_q, busy_q} <=
                {att_d, lfsr_d, bo_d, slot_d, go_d, done_d, tst_d, busy_d};
            ts_q <= ts_d;
        end
    end

    assign s_axi_awready = awr_q;
    assign s_axi_wready = wr_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_arready = arr_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;
    assign rxAccept = acc_q;
    assign rxStripPadFcs = strip_q;
    assign rxWake = wk_q;
    assign txGo = go_q;
    assign txBusy = busy_q;
    assign txDone = done_q;
    assign txStatus = tst_q;
    assign irq = irq_q;

    broadcast_reject_rej_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rxHdrValid && rxHdr.dstAddr == 48'hFFFF_FFFF_FFFF && ctrl_q[BROADCAST_REJECT_REJ_BIT] |=> !rxAccept)
        else $error("Broadcast accepted while rejected.");
    broadcast_reject_fwd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rxHdrValid && rxHdr.dstAddr == 48'hFFFF_FFFF_FFFF && !ctrl_q[BROADCAST_REJECT_REJ_BIT] |=> rxAccept)
        else $error("Broadcast dropped while allowed.");
    perfect_match_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rxHdrValid && !ctrl_q[HASH_SEL_BIT] && !(&rxHdr.dstAddr) |=>
        rxAccept == ($past(rxHdr.dstAddr) == {stah_q[15:0], stal_q}))
        else $error("Perfect filter mismatch.");
    wake_broadcast_reject_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rxHdrValid && rxHdr.isWakeup && wake_q[WAKE_EN_BIT] |=> rxWake)
        else $error("Wakeup frame missed.");
    pad_long_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rxHdrValid && rxHdr.lenField >= PAD_MIN_LEN |=> !rxStripPadFcs)
        else $error("Long frame stripped.");
    pad_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !ctrl_q[PAD_STRIP_BIT] |=> !rxStripPadFcs)
        else $error("Strip with pad strip off.");
    single_try_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ts_q == TX_SEND && txAttemptEnd && txCollision && ctrl_q[RETRY_DIS_BIT] && !txLateColl
        |=> ts_q == TX_DONE && tst_q.retryErr)
        else $error("Retry disable ignored.");
    max_tries_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        att_q <= MAX_ATTEMPTS)
        else $error("Too many attempts.");
    late_abort_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ts_q == TX_SEND && txAttemptEnd && txLateColl && txCollision && !ctrl_q[LATE_RETRY_BIT]
        |=> ts_q == TX_DONE && tst_q.lateColl)
        else $error("Late collision not abandoned.");
    backoff_cap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ts_q == TX_SEND && ts_d == TX_BACKOFF |=> {1'b0, bo_q} < (11'h001 << $past(nb)))
        else $error("Backoff above limit.");
    cov_retry_c: cover property (@(posedge ref_clk) ts_q == TX_BACKOFF ##1 ts_q == TX_SEND);
    cov_err_c: cover property (@(posedge ref_clk) done_q && tst_q.retryErr);
    cov_hash_c: cover property (@(posedge ref_clk) rxAccept && ctrl_q[HASH_SEL_BIT]);
    cov_strip_c: cover property (@(posedge ref_clk) rxStripPadFcs);
endmodule
`default_nettype wire

/* design/mfr_pkg.sv */
// Package with register map, field positions and timing constants for the MAC filter/retry block.
// Functional notes
// - Hash select clear: accept frames by exact match with the station address.
// - Hash select set: multicast frames filtered by the hash table.
// - In hash mode, unicast hashed if hash-only set, else exact match.
// - Late collision retry set: a late-collided frame is retransmitted.
// - Broadcast reject set drops broadcasts; clear forwards all broadcasts.
// - Wakeup enable lets a broadcast wakeup frame wake the device anyway.
// - Retry disabled: one attempt, drop on collision, flag retry error unless the collision was late with late retry clear.
// - Retry enabled: up to sixteen attempts before retry error.
// - Pad strip on: length field below 46 strips pad and FCS.
// - Pad strip on: length field 46 or more passes unchanged with FCS.
// - After collision wait random slots below 2^K, K = min(retries,10).
// - Random value comes from a 20-bit LFSR.
// - Load low K LFSR bits, count down once per slot to zero.
// - Two-bit backoff limit field, reset zero, caps LFSR bits used.
// - Limit 00,01,10,11 selects 10,8,4,1 bits.
package mfr_pkg;
    localparam logic [11:0] ADDR_CTRL = 12'h100;
    localparam logic [11:0] ADDR_STAH = 12'h104;
    localparam logic [11:0] ADDR_STAL = 12'h108;
    localparam logic [11:0] ADDR_HASHH = 12'h10C;
    localparam logic [11:0] ADDR_HASHL = 12'h110;
    localparam logic [11:0] ADDR_WAKE = 12'h12C;
    localparam logic [11:0] ADDR_IRQST = 12'h140;
    localparam logic [11:0] ADDR_IRQMSK = 12'h144;
    localparam logic [11:0] ADDR_TXST = 12'h148;
    localparam int HASH_SEL_BIT = 13;
    localparam int LATE_RETRY_BIT = 12;
    localparam int BROADCAST_REJECT_REJ_BIT = 11;
    localparam int RETRY_DIS_BIT = 10;
    localparam int PAD_STRIP_BIT = 8;
    localparam int BACKOFF_LIMIT_LSB = 6;
    localparam int HASH_ONLY_BIT = 15;
    localparam int WAKE_EN_BIT = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0004_0000;
    localparam logic [31:0] CTRL_WMASK = 32'h80BB_BDC0;
    localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
    localparam logic [3:0] K_MAX = 4'hA;
    localparam logic [15:0] PAD_MIN_LEN = 16'h002E;
    localparam logic [19:0] LFSR_SEED = 20'h00001;
    localparam int SLOT_BITS = 512;
    localparam int CLK_MHZ = 125;
    localparam int BIT_NS_X10 = 100;
    localparam logic [11:0] SLOT_CYCLES = 12'(SLOT_BITS * BIT_NS_X10 * CLK_MHZ / 10000);
    // Interrupt bit positions: frame accepted, wakeup, tx done, retry error, late collision.
    localparam int IRQ_RXOK = 0;
    localparam int IRQ_WAKE = 1;
    localparam int IRQ_TXDONE = 2;
    localparam int IRQ_RTYERR = 3;
    localparam int IRQ_LATE = 4;
    typedef struct packed {
        logic [47:0] dstAddr;
        logic [15:0] lenField;
        logic isWakeup;
    } mfr_rxhdr_s;
    typedef struct packed {
        logic retryErr;
        logic lateColl;
        logic [4:0] attempts;
    } mfr_txstat_s;
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_SEND = 4'b0010,
        TX_BACKOFF = 4'b0100,
        TX_DONE = 4'b1000
    } mfr_txst_e;
endpackage

/* bench/mfr_phy_model.sv */
// Behavioural far-side model that ends transmit attempts and reports collisions.
`timescale 1ns/1ps
`default_nettype none
module mfr_phy_model (
    input wire logic ref_clk, // Clock.
    input wire logic rst_n, // Async reset.
    input wire logic txGo, // Attempt start.
    input wire logic arm, // Load collision count.
    input wire logic [4:0] nColl, // Collisions to report.
    input wire logic late, // Report collisions as late.
    output logic txAttemptEnd, // Attempt end pulse.
    output logic txCollision, // Collision flag.
    output logic txLateColl // Late collision flag.
);
    logic [4:0] left;
    logic [3:0] dly;
    // Answers alternate between prompt and slow, and the flags toggle outside
    // the end pulse so that a design reading them late sees garbage.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {left, dly, txAttemptEnd, txCollision, txLateColl} <= '0;
        end
        else
        begin
            txAttemptEnd <= 1'b0;
            txCollision <= ~txCollision;
            txLateColl <= ~txLateColl;
            if (arm)
                left <= nColl;
            if (txGo)
                dly <= left[0] ? 4'h2 : 4'h9;
            else if (dly == 4'h1)
            begin
                txAttemptEnd <= 1'b1;
                txCollision <= left != 5'h00;
                txLateColl <= late && left != 5'h00;
                left <= left - 5'(left != 5'h00);
            end
            if (!txGo && dly != 4'h0)
                dly <= dly - 4'h1;
        end
    end
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench: register access, receive filtering and transmit retry.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mfr_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic rxHdrValid = 0, txStart = 0, arm = 0, late = 0;
    mfr_rxhdr_s rxHdr = '0;
    logic [4:0] nColl = '0;
    logic rxAccept, rxStripPadFcs, rxWake, txGo, txBusy, txDone, irq;
    logic txAttemptEnd, txCollision, txLateColl;
    mfr_txstat_s txStatus;
    int n_fail = 0, comparisons = 0;
    // Every byte alike, so the result does not hang on byte order in the address.
    localparam logic [47:0] U = 48'h020202020202, O = 48'h060606060606;
    localparam logic [47:0] M = 48'h030303030303, N = 48'h070707070707, B = '1;
    always #4 ref_clk = ~ref_clk;
    mfr_top uut (.*);
    mfr_phy_model phy (.*);
    task conclude;
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
             input logic [31:0] x, input logic [1:0] e);
        int i;
        @(posedge ref_clk);
        if (w)
            {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready}
                <= {a, 1'b1, d, s, 1'b1, 1'b1};
        else
            {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 1'b1, 1'b1};
        for (i = 0; i < 100; i++)
        begin
            @(posedge ref_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid || s_axi_rvalid)
                break;
        end
        {s_axi_bready, s_axi_rready} <= 2'b00;
        if (i == 100)
        begin
            n_fail++;
            conclude;
        end
        if (w)
            chk(s_axi_bresp, e);
        else
            chk({s_axi_rresp, s_axi_rdata}, {e, x});
    endtask
    task rx(input logic [47:0] d, input logic [15:0] l, input logic w, input logic [2:0] e);
        @(posedge ref_clk);
        rxHdrValid <= 1'b1;
        rxHdr <= '{d, l, w};
        @(posedge ref_clk);
        rxHdrValid <= 1'b0;
        rxHdr <= ~rxHdr;
        #1 chk({rxAccept, rxStripPadFcs, rxWake}, e);
    endtask
    task tx(input logic [4:0] c, input logic lt, input logic [6:0] st, input int gos,
            input int slots);
        int i, g, n, gm;
        {g, n, gm} = '0;
        @(posedge ref_clk);
        {arm, nColl, late, txStart} <= {1'b1, c, lt, 1'b1};
        @(posedge ref_clk);
        {arm, txStart} <= 2'b00;
        #1 chk(txBusy, 1'b1);
        for (i = 0; i < 20000 && txDone !== 1'b1; i++)
        begin
            g = txAttemptEnd ? 0 : g + 1;
            if (txGo)
            begin
                n++;
                gm = g > gm ? g : gm;
            end
            @(posedge ref_clk);
            #1;
        end
        if (i == 20000)
        begin
            n_fail++;
            conclude;
        end
        chk({txStatus, 32'(n)}, {st, 32'(gos)});
        // A backoff is whole slots plus a few cycles of handshake.
        chk(gm <= slots * SLOT_CYCLES + 16, 1'b1);
    endtask
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus(0, ADDR_CTRL, 0, 0, CTRL_RESET, 2'b00);
        bus(0, 12'h114, 0, 0, 32'h0000_0000, 2'b10);
        bus(1, ADDR_CTRL, 32'hFFFF_FFFF, 4'hF, 0, 2'b00);
        bus(0, ADDR_CTRL, 0, 0, CTRL_WMASK | CTRL_RESET, 2'b00);
        bus(1, ADDR_CTRL, 32'h0000_0000, 4'h1, 0, 2'b00);
        bus(0, ADDR_CTRL, 0, 0, (CTRL_WMASK | CTRL_RESET) & 32'hFFFF_FF00, 2'b00);
        bus(1, ADDR_CTRL, 32'h0000_0000, 4'hF, 0, 2'b00);
        bus(1, ADDR_STAH, 32'h0000_0202, 4'hF, 0, 2'b00);
        bus(1, ADDR_STAL, 32'h0202_0202, 4'hF, 0, 2'b00);
        bus(1, ADDR_HASHH, 32'h0000_0048, 4'hF, 0, 2'b00);
        bus(1, ADDR_HASHL, 32'h0000_0048, 4'hF, 0, 2'b00);
        bus(1, ADDR_IRQMSK, 32'h0000_0001, 4'hF, 0, 2'b00);
        rx(U, 16'h0100, 1'b0, 3'b100);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1'b1);
        bus(0, ADDR_IRQST, 0, 0, 32'h0000_0001, 2'b00);
        bus(0, ADDR_IRQST, 0, 0, 32'h0000_0000, 2'b00);
        chk(irq, 1'b0);
        bus(1, ADDR_IRQMSK, 32'h0000_0000, 4'hF, 0, 2'b00);
        rx(O, 16'h0100, 1'b0, 3'b000);
        rx(M, 16'h0100, 1'b0, 3'b000);
        rx(B, 16'h0100, 1'b0, 3'b100);
        chk(irq, 1'b0);
        bus(0, ADDR_IRQST, 0, 0, 32'h0000_0001, 2'b00);
        bus(1, ADDR_CTRL, 32'h0000_2000, 4'hF, 0, 2'b00);
        rx(M, 16'h0100, 1'b0, 3'b100);
        rx(N, 16'h0100, 1'b0, 3'b000);
        rx(U, 16'h0100, 1'b0, 3'b100);
        rx(O, 16'h0100, 1'b0, 3'b000);
        bus(1, ADDR_CTRL, 32'h0000_A000, 4'hF, 0, 2'b00);
        rx(U, 16'h0100, 1'b0, 3'b000);
        rx(O, 16'h0100, 1'b0, 3'b100);
        bus(1, ADDR_CTRL, 32'h0000_0800, 4'hF, 0, 2'b00);
        rx(B, 16'h0100, 1'b0, 3'b000);
        bus(1, ADDR_WAKE, 32'h0000_0004, 4'hF, 0, 2'b00);
        rx(B, 16'h0100, 1'b1, 3'b001);
        bus(1, ADDR_CTRL, 32'h0000_0100, 4'hF, 0, 2'b00);
        rx(U, 16'h002D, 1'b0, 3'b110);
        rx(U, 16'h002E, 1'b0, 3'b100);
        bus(1, ADDR_CTRL, 32'h0000_0000, 4'hF, 0, 2'b00);
        rx(U, 16'h002D, 1'b0, 3'b100);
        bus(1, ADDR_CTRL, 32'h0000_0400, 4'hF, 0, 2'b00);
        tx(5'h01, 1'b0, {1'b1, 1'b0, 5'h01}, 1, 0);
        bus(1, ADDR_CTRL, 32'h0000_0000, 4'hF, 0, 2'b00);
        tx(5'h02, 1'b0, {1'b0, 1'b0, 5'h03}, 3, 3);
        bus(1, ADDR_CTRL, 32'h0000_00C0, 4'hF, 0, 2'b00);
        tx(5'h10, 1'b0, {1'b1, 1'b0, MAX_ATTEMPTS}, 16, 1);
        tx(5'h01, 1'b1, {1'b0, 1'b1, 5'h01}, 1, 0);
        bus(1, ADDR_CTRL, 32'h0000_10C0, 4'hF, 0, 2'b00);
        tx(5'h01, 1'b1, {1'b0, 1'b1, 5'h02}, 2, 1);
        // Every event kind has fired since the last clear: accept, wake, done, retry, late.
        bus(0, ADDR_IRQST, 0, 0, 32'h0000_001F, 2'b00);
        conclude;
    end
endmodule
`default_nettype wire
